/* hw/scroll_cmd_ctrl.sv */
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: host stops horizontal scroll before setup
// R2: take right/left setup: start, speed, end
// R3: scroll rotates all 128 columns per step
// R4: diagonal setup is six bytes, two directions
// R5: three 3-bit horizontal fields, 6-bit offset
// R6: zero vertical offset means horizontal only
// R7: host stops scroll before diagonal setup
// R8: stop command halts all scroll motion
// R9: host rewrites memory after stopping
// R10: start command runs with stored parameters
// R11: host starts only after a setup
// R12: one parameter set, newest setup replaces
// R13: host makes no memory access while scrolling
// R14: host keeps parameters while scrolling
// R15: scroll area command is three bytes
// R16: host keeps area rows within multiplex
// R17: frame equals clock over divide*row*39
// R18: default divide two, 54 clocks per row
// R19: 4-bit divide ratio, reset 0001b
// R20: 4-bit oscillator field, default 1100b
// R21: column leaving one edge enters opposite
module scroll_cmd_ctrl (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CLOCK_SOURCE_SELECT_PIN,
	output logic SCROLL_ACTIVE,
	output logic [5:0] VERTICAL_SHIFT,
	output logic DISPLAY_CLOCK,
	output logic FRAME_START,
	output logic [3:0] OSC_FREQ
);
	scroll_pkg::state_s s_q;
	scroll_pkg::state_s s_d;
	logic ram_we;
	logic [9:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;
	logic acc_new;
	logic is_data;
	logic host_ram;
	logic byte_taken;
	logic display_clock_tick;
	logic row_tick;
	logic frame_tick;
	logic step;
	logic [6:0] col_nxt;
	logic [6:0] col_first;
	logic [6:0] col_last;

	// ==========================================================
	// helpers
	function automatic logic [5:0] wrap_add(input logic [5:0] v,
		input logic [5:0] off, input logic [6:0] rows);
		logic [6:0] sum;
		sum = {1'b0, v} + {1'b0, off};
		if (rows == 7'h00) begin
			sum = 7'h00;
		end else begin
			if (sum >= rows) begin
				sum = sum - rows;
			end
			if (sum >= rows) begin
				sum = sum - rows;
			end
		end
		return sum[5:0];
	endfunction : wrap_add

	function automatic logic is_scroll_op(input logic [7:0] op);
		return op == scroll_pkg::OP_HSCR_RIGHT
			|| op == scroll_pkg::OP_HSCR_LEFT
			|| op == scroll_pkg::OP_DSCR_RIGHT
			|| op == scroll_pkg::OP_DSCR_LEFT;
	endfunction : is_scroll_op

	scroll_frame_ram #(
		.WIDTH(8),
		.AWIDTH(10)
	) u_ram (
		.clk(CLOCK),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	// ==========================================================
	// bus decode and timing chain
	assign acc_new = PSEL && PENABLE && !s_q.pend && !s_q.pready;
	assign is_data = PADDR == scroll_pkg::OFS_DATA;
	assign host_ram = acc_new && is_data && s_q.fsm == scroll_pkg::ROT_IDLE;
	assign byte_taken = s_q.pend && PWRITE && PADDR == scroll_pkg::OFS_CMD;
	assign display_clock_tick = s_q.div_cnt >= s_q.cfg.div_ratio;
	assign row_tick = display_clock_tick && s_q.display_clock_cnt == scroll_pkg::ROW_CLK_LAST;
	assign frame_tick = row_tick && s_q.row_cnt == scroll_pkg::MUX_LAST;
	assign step = frame_tick && s_q.active
		&& s_q.frame_cnt == s_q.cfg.speed;
	assign col_nxt = s_q.cfg.dir_left ? s_q.col + 7'h01 : s_q.col - 7'h01;
	assign col_first = s_q.cfg.dir_left ? 7'h00 : scroll_pkg::COL_LAST;
	assign col_last = s_q.cfg.dir_left ? scroll_pkg::COL_LAST : 7'h00;

	always_comb begin
		s_d = s_q;
		ram_we = 1'b0;
		ram_addr = {s_q.page, s_q.col};
		ram_wdata = ram_rdata;

		// ======================================================
		// frame timing: divider, row period, frame, step
		s_d.display_clock_pulse = display_clock_tick;
		s_d.frame_pulse = frame_tick;
		s_d.div_cnt = display_clock_tick ? 4'h0 : s_q.div_cnt + 4'h1; // R19
		if (display_clock_tick) begin
			s_d.display_clock_cnt = row_tick ? 6'h00 : s_q.display_clock_cnt + 6'h01; // R18
		end
		if (row_tick) begin
			s_d.row_cnt = frame_tick ? 6'h00 : s_q.row_cnt + 6'h01; // R17
		end
		if (frame_tick && s_q.active) begin
			s_d.frame_cnt = step ? 3'h0 : s_q.frame_cnt + 3'h1;
		end
		s_d.osc_out = CLOCK_SOURCE_SELECT_PIN ? s_q.cfg.osc_freq : 4'h0; // R20

		// ======================================================
		// column rotation engine, one page at a time
		unique case (s_q.fsm)
			scroll_pkg::ROT_IDLE: begin
				if (host_ram) begin
					ram_addr = s_q.ptr;
					ram_we = PWRITE;
					ram_wdata = PWDATA[7:0];
				end
				if (step) begin
					s_d.fsm = scroll_pkg::ROT_SAVE;
					s_d.page = s_q.cfg.start_page;
					s_d.col = col_first;
				end
			end
			scroll_pkg::ROT_SAVE: begin
				s_d.fsm = scroll_pkg::ROT_HOLD;
			end
			scroll_pkg::ROT_HOLD: begin
				// the edge byte is parked until the tail write
				s_d.hold = ram_rdata; // R21
				ram_addr = {s_q.page, col_nxt};
				s_d.fsm = scroll_pkg::ROT_WRITE;
			end
			scroll_pkg::ROT_FETCH: begin
				ram_addr = {s_q.page, col_nxt};
				s_d.fsm = scroll_pkg::ROT_WRITE;
			end
			scroll_pkg::ROT_WRITE: begin
				ram_we = 1'b1; // R3
				s_d.col = col_nxt;
				s_d.fsm = col_nxt == col_last ? scroll_pkg::ROT_TAIL
					: scroll_pkg::ROT_FETCH;
			end
			scroll_pkg::ROT_TAIL: begin
				ram_we = 1'b1;
				ram_wdata = s_q.hold; // R21
				if (s_q.page == s_q.cfg.end_page) begin
					s_d.fsm = scroll_pkg::ROT_IDLE;
				end else begin
					s_d.page = s_q.page + 3'h1;
					s_d.col = col_first;
					s_d.fsm = scroll_pkg::ROT_SAVE;
				end
			end
		endcase
		if (step && s_q.cfg.voff != 6'h00) begin // R6
			s_d.vshift = wrap_add(s_q.vshift, s_q.cfg.voff,
				s_q.cfg.area_rows);
		end

		// ======================================================
		// bus slave: access cycle, then answer two cycles later
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		if (acc_new && (!is_data || s_q.fsm == scroll_pkg::ROT_IDLE)) begin
			s_d.pend = 1'b1;
		end
		if (s_q.pend) begin
			s_d.pend = 1'b0;
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0;
			unique case (PADDR)
				scroll_pkg::OFS_CMD: begin
				end
				scroll_pkg::OFS_DATA: begin
					if (!PWRITE) begin
						s_d.prdata = {24'h0, ram_rdata};
					end
					s_d.ptr = {s_q.ptr[9:7], s_q.ptr[6:0] + 7'h01};
				end
				scroll_pkg::OFS_PTR: begin
					if (PWRITE) begin
						s_d.ptr = PWDATA[9:0];
					end
					s_d.prdata = {22'h0, s_q.ptr};
				end
				scroll_pkg::OFS_STATUS: begin
					s_d.prdata[scroll_pkg::STS_ACTIVE] = s_q.active;
					s_d.prdata[scroll_pkg::STS_BUSY] =
						s_q.fsm != scroll_pkg::ROT_IDLE;
					s_d.prdata[scroll_pkg::STS_PENDING] = s_q.pleft != 3'h0;
					s_d.prdata[scroll_pkg::STS_VSHIFT +: 6] = s_q.vshift;
					s_d.prdata[scroll_pkg::STS_OPCODE +: 8] = s_q.opcode;
				end
				scroll_pkg::OFS_CLKCFG: begin
					s_d.prdata[scroll_pkg::CLK_DIV +: 4] = s_q.cfg.div_ratio;
					s_d.prdata[scroll_pkg::CLK_OSC +: 4] = s_q.cfg.osc_freq;
				end
				scroll_pkg::OFS_CFG: begin
					s_d.prdata[scroll_pkg::CFG_START +: 3] = s_q.cfg.start_page;
					s_d.prdata[scroll_pkg::CFG_END +: 3] = s_q.cfg.end_page;
					s_d.prdata[scroll_pkg::CFG_SPEED +: 3] = s_q.cfg.speed;
					s_d.prdata[scroll_pkg::CFG_LEFT] = s_q.cfg.dir_left;
					s_d.prdata[scroll_pkg::CFG_VOFF +: 6] = s_q.cfg.voff;
				end
				scroll_pkg::OFS_VAREA: begin
					s_d.prdata[scroll_pkg::VA_FIXED +: 6] = s_q.cfg.fixed_rows;
					s_d.prdata[scroll_pkg::VA_ROWS +: 7] = s_q.cfg.area_rows;
				end
				default: begin
					s_d.pslverr = 1'b1;
				end
			endcase
		end

		// ======================================================
		// command byte interpreter
		if (byte_taken && s_q.pleft == 3'h0) begin
			s_d.opcode = PWDATA[7:0];
			s_d.pidx = scroll_pkg::PIDX_FIRST;
			case (PWDATA[7:0])
				scroll_pkg::OP_HSCR_RIGHT, scroll_pkg::OP_HSCR_LEFT: begin
					s_d.pleft = scroll_pkg::NP_HSCR; // R2
					s_d.cfg.dir_left = PWDATA[0]; // R12
					s_d.cfg.voff = 6'h00;
				end
				scroll_pkg::OP_DSCR_RIGHT, scroll_pkg::OP_DSCR_LEFT: begin
					s_d.pleft = scroll_pkg::NP_DSCR; // R4
					s_d.cfg.dir_left = !PWDATA[0];
				end
				scroll_pkg::OP_VAREA: begin
					s_d.pleft = scroll_pkg::NP_VAREA; // R15
				end
				scroll_pkg::OP_CLKDIV: begin
					s_d.pleft = scroll_pkg::NP_CLKDIV;
				end
				scroll_pkg::OP_STOP: begin
					// a page left half rotated is the host's to rewrite
					s_d.active = 1'b0; // R8
					s_d.fsm = scroll_pkg::ROT_IDLE;
					s_d.frame_cnt = 3'h0;
				end
				scroll_pkg::OP_START: begin
					s_d.active = 1'b1; // R10
					s_d.frame_cnt = 3'h0;
				end
				default: begin
				end
			endcase
		end else if (byte_taken) begin
			s_d.pleft = s_q.pleft - 3'h1;
			s_d.pidx = s_q.pidx + 3'h1;
			if (is_scroll_op(s_q.opcode)) begin
				unique case (s_q.pidx)
					scroll_pkg::PIDX_START:
						s_d.cfg.start_page = PWDATA[2:0]; // R5
					scroll_pkg::PIDX_SPEED:
						s_d.cfg.speed = PWDATA[2:0]; // R5
					scroll_pkg::PIDX_END:
						s_d.cfg.end_page = PWDATA[2:0]; // R5
					scroll_pkg::PIDX_VOFF: begin
						if (!s_q.opcode[2]) begin
							s_d.cfg.voff = PWDATA[5:0]; // R5
						end
					end
					default: begin
					end
				endcase
			end else if (s_q.opcode == scroll_pkg::OP_VAREA) begin
				if (s_q.pidx == scroll_pkg::PIDX_FIRST) begin
					s_d.cfg.fixed_rows = PWDATA[5:0];
				end else begin
					s_d.cfg.area_rows = PWDATA[6:0]; // R15
				end
			end else begin
				s_d.cfg.div_ratio = PWDATA[3:0]; // R19
				s_d.cfg.osc_freq = PWDATA[7:4]; // R20
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			s_q <= '0;
			s_q.fsm <= scroll_pkg::ROT_IDLE;
			s_q.cfg.div_ratio <= scroll_pkg::DIV_RESET; // R18
			s_q.cfg.osc_freq <= scroll_pkg::OSC_RESET;
			s_q.cfg.area_rows <= scroll_pkg::AREA_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign PRDATA = s_q.prdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.pslverr;
	assign SCROLL_ACTIVE = s_q.active;
	assign VERTICAL_SHIFT = s_q.vshift;
	assign DISPLAY_CLOCK = s_q.display_clock_pulse;
	assign FRAME_START = s_q.frame_pulse;
	assign OSC_FREQ = s_q.osc_out;

	// ==========================================================
	// checks
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	logic [6:0] wr_cnt_q;
	logic [15:0] gap_q;
	logic seen_q;
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			wr_cnt_q <= 7'h00;
			gap_q <= 16'h0001;
			seen_q <= 1'b0;
		end else begin
			if (s_q.fsm == scroll_pkg::ROT_SAVE) begin
				wr_cnt_q <= 7'h00;
			end else if (s_q.fsm == scroll_pkg::ROT_WRITE) begin
				wr_cnt_q <= wr_cnt_q + 7'h01;
			end
			gap_q <= frame_tick ? 16'h0001 : gap_q + 16'h0001;
			if (s_d.cfg.div_ratio != s_q.cfg.div_ratio) begin
				seen_q <= 1'b0;
			end else if (frame_tick) begin
				seen_q <= 1'b1;
			end
		end
	end

	sequence seq_rot_open;
		s_q.fsm == scroll_pkg::ROT_SAVE ##1 s_q.fsm == scroll_pkg::ROT_HOLD;
	endsequence

	rot_open_a: assert property (seq_rot_open |=> // R3
		s_q.fsm == scroll_pkg::ROT_WRITE && ram_we)
		else $error("rotation did not begin writing");
	tail_wrap_a: assert property (s_q.fsm == scroll_pkg::ROT_TAIL // R21
		|-> ram_we && ram_wdata == s_q.hold && s_q.col == col_last
		&& wr_cnt_q == scroll_pkg::COL_LAST)
		else $error("edge byte not wrapped after 127 moves");
	stop_halts_a: assert property (byte_taken && s_q.pleft == 3'h0 // R8
		&& PWDATA[7:0] == scroll_pkg::OP_STOP
		|=> !SCROLL_ACTIVE && s_q.fsm == scroll_pkg::ROT_IDLE)
		else $error("stop left scroll running");
	start_runs_a: assert property (byte_taken && s_q.pleft == 3'h0 // R10
		&& PWDATA[7:0] == scroll_pkg::OP_START |=> ##1 SCROLL_ACTIVE)
		else $error("start did not activate scroll");
	hscr_len_a: assert property (byte_taken && s_q.pleft == 3'h0 // R2
		&& PWDATA[7:0] == scroll_pkg::OP_HSCR_LEFT
		|=> s_q.pleft == scroll_pkg::NP_HSCR && s_q.cfg.dir_left)
		else $error("horizontal setup length or direction wrong");
	dscr_len_a: assert property (byte_taken && s_q.pleft == 3'h0 // R4
		&& PWDATA[7:0] == scroll_pkg::OP_DSCR_RIGHT
		|=> s_q.pleft == scroll_pkg::NP_DSCR && !s_q.cfg.dir_left)
		else $error("diagonal setup length or direction wrong");
	voff_take_a: assert property (byte_taken && s_q.pidx == // R5
		scroll_pkg::PIDX_VOFF && s_q.opcode == scroll_pkg::OP_DSCR_LEFT
		|=> s_q.cfg.voff == $past(PWDATA[5:0]))
		else $error("vertical offset not stored");
	horiz_only_a: assert property (step && s_q.cfg.voff == 6'h00 // R6
		|=> $stable(VERTICAL_SHIFT))
		else $error("zero offset moved rows");
	varea_len_a: assert property (byte_taken && s_q.pleft == 3'h0 // R15
		&& PWDATA[7:0] == scroll_pkg::OP_VAREA
		|=> s_q.pleft == scroll_pkg::NP_VAREA)
		else $error("scroll area length wrong");
	clk_field_a: assert property (byte_taken && s_q.pleft == 3'h1 // R19
		&& s_q.opcode == scroll_pkg::OP_CLKDIV |=> s_q.cfg.div_ratio ==
		$past(PWDATA[3:0]) && s_q.cfg.osc_freq == $past(PWDATA[7:4]))
		else $error("clock fields not stored");
	frame_rate_a: assert property (frame_tick && seen_q |-> // R17
		gap_q == 16'(({12'h0, s_q.cfg.div_ratio} + 16'h0001)
		* scroll_pkg::ROW_CLOCKS * scroll_pkg::MUX_ROWS))
		else $error("frame period wrong");
endmodule : scroll_cmd_ctrl
`default_nettype wire

/* hw/scroll_pkg.sv */
`default_nettype none
package scroll_pkg;
	// ==========================================================
	// register map, byte addresses on the bus
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_PTR = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_CLKCFG = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h14;
	localparam logic [7:0] OFS_VAREA = 8'h18;

	// ==========================================================
	// field positions (least significant bit of each field)
	localparam int STS_ACTIVE = 0;
	localparam int STS_BUSY = 1;
	localparam int STS_PENDING = 2;
	localparam int STS_VSHIFT = 8;
	localparam int STS_OPCODE = 16;
	localparam int CLK_DIV = 0;
	localparam int CLK_OSC = 4;
	localparam int CFG_START = 0;
	localparam int CFG_END = 4;
	localparam int CFG_SPEED = 8;
	localparam int CFG_LEFT = 12;
	localparam int CFG_VOFF = 16;
	localparam int VA_FIXED = 0;
	localparam int VA_ROWS = 8;

	// ==========================================================
	// command bytes and parameter counts
	localparam logic [7:0] OP_HSCR_RIGHT = 8'h26;
	localparam logic [7:0] OP_HSCR_LEFT = 8'h27;
	localparam logic [7:0] OP_DSCR_RIGHT = 8'h29;
	localparam logic [7:0] OP_DSCR_LEFT = 8'h2a;
	localparam logic [7:0] OP_STOP = 8'h2e;
	localparam logic [7:0] OP_START = 8'h2f;
	localparam logic [7:0] OP_VAREA = 8'ha3;
	localparam logic [7:0] OP_CLKDIV = 8'hd5;
	localparam logic [2:0] NP_HSCR = 3'h6;
	localparam logic [2:0] NP_DSCR = 3'h5;
	localparam logic [2:0] NP_VAREA = 3'h2;
	localparam logic [2:0] NP_CLKDIV = 3'h1;
	localparam logic [2:0] PIDX_FIRST = 3'h1;
	localparam logic [2:0] PIDX_START = 3'h2;
	localparam logic [2:0] PIDX_SPEED = 3'h3;
	localparam logic [2:0] PIDX_END = 3'h4;
	localparam logic [2:0] PIDX_VOFF = 3'h5;

	// ==========================================================
	// geometry, timing counts and reset values
	localparam logic [6:0] COL_LAST = 7'h7f;
	localparam logic [5:0] ROW_CLK_LAST = 6'h35;
	localparam logic [5:0] MUX_LAST = 6'h26;
	localparam logic [15:0] ROW_CLOCKS = 16'h0036;
	localparam logic [15:0] MUX_ROWS = 16'h0027;
	localparam logic [3:0] DIV_RESET = 4'h1;
	localparam logic [3:0] OSC_RESET = 4'hc;
	localparam logic [6:0] AREA_RESET = 7'h27;

	typedef enum logic [5:0] {
		ROT_IDLE = 6'b000001,
		ROT_SAVE = 6'b000010,
		ROT_HOLD = 6'b000100,
		ROT_FETCH = 6'b001000,
		ROT_WRITE = 6'b010000,
		ROT_TAIL = 6'b100000
	} rot_e;

	typedef struct packed {
		logic dir_left;
		logic [2:0] start_page;
		logic [2:0] end_page;
		logic [2:0] speed;
		logic [5:0] voff;
		logic [5:0] fixed_rows;
		logic [6:0] area_rows;
		logic [3:0] div_ratio;
		logic [3:0] osc_freq;
	} cfg_s;

	typedef struct packed {
		cfg_s cfg;
		rot_e fsm;
		logic active;
		logic [7:0] opcode;
		logic [2:0] pidx;
		logic [2:0] pleft;
		logic [2:0] page;
		logic [6:0] col;
		logic [7:0] hold;
		logic [9:0] ptr;
		logic [3:0] div_cnt;
		logic [5:0] display_clock_cnt;
		logic [5:0] row_cnt;
		logic [2:0] frame_cnt;
		logic [5:0] vshift;
		logic pend;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic frame_pulse;
		logic display_clock_pulse;
		logic [3:0] osc_out;
	} state_s;
endpackage : scroll_pkg
`default_nettype wire

/* hw/scroll_frame_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module scroll_frame_ram #(
	parameter int WIDTH = 8,
	parameter int AWIDTH = 10
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AWIDTH-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);
	// ==========================================================
	// single port, read data registered, old data on a write
	logic [WIDTH-1:0] mem [0:(1<<AWIDTH)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : scroll_frame_ram
`default_nettype wire

/* verif/scroll_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host side: apb master that issues commands and data
module scroll_host (
	input wire logic clk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep showing the old value
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : scroll_host
`default_nettype wire

/* verif/oled_scroll_command_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module oled_scroll_command_control_tb;
	logic clock, rst, pin, psel, penable, pwrite, pready, pslverr;
	logic active, display_clock, frame;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0] vshift;
	logic [3:0] osc, ov;
	logic [31:0] exp_d[$];
	logic exp_e[$];
	logic [7:0] img[128];
	logic [7:0] ops[4];
	logic [6:0] rows;
	logic [5:0] fx;
	logic [2:0] pg;
	int miscompares = 0;
	int samples_checked = 0;
	int n;
	int ev = 0;

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	scroll_cmd_ctrl DUT (.CLOCK(clock), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CLOCK_SOURCE_SELECT_PIN(pin),
		.SCROLL_ACTIVE(active), .VERTICAL_SHIFT(vshift),
		.DISPLAY_CLOCK(display_clock), .FRAME_START(frame), .OSC_FREQ(osc));

	scroll_host host_model (.clk(clock), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));

	// ==========================================
	// helpers
	task automatic check(input logic [31:0] got, input logic [31:0] e,
		input string m);
		samples_checked++;
		if (got !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m,
				got, e);
		end
	endtask : check

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic err);
		exp_d.push_back(e);
		exp_e.push_back(err);
		host_model.xfer(1'b0, a, 32'h00000000);
	endtask : rd

	task automatic cmd(input logic [7:0] b);
		host_model.xfer(1'b1, scroll_pkg::OFS_CMD, {24'h000000, b});
	endtask : cmd

	task automatic wait_pulse(input logic f, output int c);
		c = 0;
		do begin
			@(posedge clock);
			c++;
		end while ((f ? frame : display_clock) !== 1'b1 && c < 9000);
	endtask : wait_pulse

	task automatic final_report;
		$display("checked %0d, wrong %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	// ==========================================
	// read monitor: oldest note against each answered read
	always @(posedge clock) begin
		if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0) begin
			if (exp_d.size() == 0) begin
				miscompares++;
				$display("wrong value at %0t: unexpected read", $time);
			end else begin
				check(prdata, exp_d.pop_front(), "read data");
				check({31'h0, pslverr}, {31'h0, exp_e.pop_front()}, "err");
			end
		end
	end

	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		$display("wrong value at %0t: watchdog ran out", $time);
		final_report();
	end

	// ==========================================
	// main sequence
	initial begin
		rst = 1'b1;
		pin = 1'b1;
		ops = '{scroll_pkg::OP_HSCR_RIGHT, scroll_pkg::OP_HSCR_LEFT,
			scroll_pkg::OP_DSCR_RIGHT, scroll_pkg::OP_DSCR_LEFT};
		void'($urandom(41));
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(scroll_pkg::OFS_CLKCFG, 32'h000000c1, 1'b0);
		rd(scroll_pkg::OFS_VAREA, 32'h00002700, 1'b0);
		rd(scroll_pkg::OFS_STATUS, 32'h00000000, 1'b0);
		rd(8'h1c, 32'h00000000, 1'b1);
		check({28'h0, osc}, 32'h0000000c, "osc at reset");
		$display("reset values done");

		wait_pulse(1'b1, n);
		wait_pulse(1'b1, n);
		check(n, 2 * 54 * 39, "frame gap at reset");
		wait_pulse(1'b0, n);
		wait_pulse(1'b0, n);
		check(n, 2, "display clock gap");
		ov = 4'($urandom);
		cmd(scroll_pkg::OP_CLKDIV);
		cmd({ov, 4'h0});
		rd(scroll_pkg::OFS_CLKCFG, {24'h0, ov, 4'h0}, 1'b0);
		check({28'h0, osc}, {28'h0, ov}, "osc follows field");
		wait_pulse(1'b1, n);
		wait_pulse(1'b1, n);
		check(n, 54 * 39, "frame gap divide one");
		pin <= 1'b0;
		repeat (3) @(posedge clock);
		check({28'h0, osc}, 32'h00000000, "osc with pin low");
		pin <= 1'b1;
		$display("clock timing done");

		fx = 6'($urandom);
		rows = 7'($urandom_range(39, 6));
		cmd(scroll_pkg::OP_VAREA);
		cmd({2'h0, fx});
		cmd({1'h0, rows});
		rd(scroll_pkg::OFS_VAREA, {17'h0, rows, 2'h0, fx}, 1'b0);
		$display("scroll area done");

		for (int k = 0; k < 4; k++) begin
			pg = 3'($urandom_range(7));
			host_model.xfer(1'b1, scroll_pkg::OFS_PTR, {22'h0, pg, 7'h00});
			for (int c = 0; c < 128; c++) begin
				img[c] = 8'($urandom);
				host_model.xfer(1'b1, scroll_pkg::OFS_DATA, {24'h0, img[c]});
			end
			// scroll is stopped here, so setup is legal
			cmd(ops[k]);
			cmd(8'h00);
			cmd({5'h0, pg});
			cmd(8'h00);
			cmd({5'h0, pg});
			cmd(k >= 2 ? 8'h05 : 8'h00);
			if (k < 2) begin
				cmd(8'hff);
			end
			rd(scroll_pkg::OFS_CFG, {10'h0, (k >= 2 ? 6'h05 : 6'h00), 3'h0,
				(k % 2 == 1), 1'b0, 3'h0, 1'b0, pg, 1'b0, pg}, 1'b0);
			rd(scroll_pkg::OFS_STATUS, {8'h0, ops[k], 2'h0, 6'(ev), 8'h00},
				1'b0);
			cmd(scroll_pkg::OP_START);
			repeat (2) @(posedge clock);
			check({31'h0, active}, 32'h00000001, "active after start");
			wait_pulse(1'b1, n);
			repeat (400) @(posedge clock);
			// the vertical offset wraps inside the scroll area
			if (k >= 2) begin
				ev = (ev + 5) % rows;
			end
			check({26'h0, vshift}, 32'(ev), "shift");
			cmd(scroll_pkg::OP_STOP);
			repeat (2) @(posedge clock);
			check({31'h0, active}, 32'h00000000, "active after stop");
			host_model.xfer(1'b1, scroll_pkg::OFS_PTR, {22'h0, pg, 7'h00});
			for (int c = 0; c < 128; c++) begin
				rd(scroll_pkg::OFS_DATA, {24'h0, (k % 2 == 1) ?
					img[(c + 1) % 128] : img[(c + 127) % 128]}, 1'b0);
			end
			rd(scroll_pkg::OFS_PTR, {22'h0, pg, 7'h00}, 1'b0);
			$display("scroll case %0d done", k);
		end
		repeat (4) @(posedge clock);
		final_report();
	end
endmodule : oled_scroll_command_control_tb
`default_nettype wire
